//--- tcmp_pkg.sv
package tcmp_pkg;
    localparam logic [7:0] CNT_MAX     = 8'hff;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] CMP_RESET   = 8'h00;
    localparam logic [2:0] WGM_NORMAL  = 3'h0;
    localparam logic [2:0] WGM_CTC     = 3'h2;
    localparam logic [1:0] COM_NONE    = 2'h0;
    localparam logic [1:0] COM_TOGGLE  = 2'h1;
    localparam logic [1:0] COM_CLEAR   = 2'h2;
    localparam logic [1:0] COM_SET     = 2'h3;
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_RESET   = 10'h000;
    localparam logic [9:0] PRE_M8      = 10'h007;
    localparam logic [9:0] PRE_M64     = 10'h03f;
    localparam logic [9:0] PRE_M256    = 10'h0ff;
    localparam logic [9:0] PRE_M1024   = 10'h3ff;
endpackage

//--- tcmp_timer.sv
`timescale 1ns/10ps
module tcmp_timer (
    // clock, reset, enable
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    // configuration
    input  wire logic [2:0]           i_clock_select_field,
    input  wire logic [2:0]           i_waveform_gen_mode,
    input  wire logic [1:0]           i_compare_a_output_mode,
    input  wire logic [1:0]           i_compare_b_output_mode,
    input  wire logic [7:0]           i_compare_a_value,
    input  wire logic [7:0]           i_compare_b_value,
    input  wire logic                 i_ext_clk_pin,
    // count access
    input  wire logic                 i_count_wr,
    input  wire logic [7:0]           i_count_wdata,
    // force strobes and flag clears
    input  wire logic                 i_force_compare_strobe_a,
    input  wire logic                 i_force_compare_strobe_b,
    input  wire logic                 i_compare_a_flag_clr,
    input  wire logic                 i_compare_b_flag_clr,
    input  wire logic                 i_overflow_flag_clr,
    input  wire logic                 i_compare_a_irq_ack,
    input  wire logic                 i_compare_b_irq_ack,
    input  wire logic                 i_overflow_irq_ack,
    // port pins
    input  wire logic                 i_port_a_value,
    input  wire logic                 i_port_b_value,
    input  wire logic                 i_compare_pin_direction_bit_a,
    input  wire logic                 i_compare_pin_direction_bit_b,
    // outputs
    output      logic [7:0]           o_timer_count_value,
    output      logic                 o_overflow_flag,
    output      logic                 o_compare_a_flag,
    output      logic                 o_compare_b_flag,
    output      logic                 o_compare_output_a,
    output      logic                 o_compare_output_b,
    output      logic                 o_pin_a_out,
    output      logic                 o_pin_a_oe_n,
    output      logic                 o_pin_b_out,
    output      logic                 o_pin_b_oe_n
);
    import tcmp_pkg::*;

    logic [9:0] prescale;
    logic       ext_prev;
    logic       block_next;
    logic [7:0] count;
    logic       ovf;
    logic       flag_a;
    logic       flag_b;
    logic       oc_a;
    logic       oc_b;

    // prescaler runs free; divisors taken as taps of one counter
    wire [9:0] next_prescale = prescale + 10'h001;
    wire ext_fall = ext_prev & ~i_ext_clk_pin;
    wire ext_rise = ~ext_prev & i_ext_clk_pin;
    wire tick =
        (i_clock_select_field == CS_DIV1) ? 1'b1 :
        (i_clock_select_field == CS_DIV8) ? ((prescale & PRE_M8) == PRE_M8) :
        (i_clock_select_field == CS_DIV64) ? ((prescale & PRE_M64) == PRE_M64) :
        (i_clock_select_field == CS_DIV256) ? ((prescale & PRE_M256) == PRE_M256) :
        (i_clock_select_field == CS_DIV1024) ? (prescale == PRE_M1024) :
        (i_clock_select_field == CS_EXT_FALL) ? ext_fall :
        (i_clock_select_field == CS_EXT_RISE) ? ext_rise : 1'b0;

    wire mode_ctc  = (i_waveform_gen_mode == WGM_CTC);
    wire non_pwm   = (i_waveform_gen_mode == WGM_NORMAL) || mode_ctc;
    // compares are unbuffered in non-PWM modes, so a low new top just waits for wrap
    wire eq_a      = (count == i_compare_a_value);
    wire eq_b      = (count == i_compare_b_value);
    wire match_a   = tick & eq_a & ~block_next;
    wire match_b   = tick & eq_b & ~block_next;
    // the clear is a match action, so a pending count write blocks it too
    wire ctc_clear = tick & mode_ctc & eq_a & ~block_next;
    wire wrap      = tick & ~ctc_clear & (count == CNT_MAX);
    wire ovf_set   = wrap;
    wire [7:0] next_count =
        i_count_wr ? i_count_wdata :
        ctc_clear  ? CNT_BOTTOM :
        tick       ? count + 8'h01 : count;

    // action per output mode; zero holds the state
    function automatic logic oc_action(input logic [1:0] mode, input logic cur);
        unique case (mode)
            COM_NONE:   oc_action = cur;
            COM_TOGGLE: oc_action = ~cur;
            COM_CLEAR:  oc_action = 1'b0;
            COM_SET:    oc_action = 1'b1;
        endcase
    endfunction

    // force acts like a match on the state only
    wire act_a = match_a | (i_force_compare_strobe_a & non_pwm);
    wire act_b = match_b | (i_force_compare_strobe_b & non_pwm);
    // mode read live at the match, never buffered with the compare value
    wire next_oc_a = act_a ? oc_action(i_compare_a_output_mode, oc_a) : oc_a;
    wire next_oc_b = act_b ? oc_action(i_compare_b_output_mode, oc_b) : oc_b;

    // set wins over clear so no event is lost
    wire next_ovf = ovf_set | (ovf & ~i_overflow_flag_clr & ~i_overflow_irq_ack);
    wire next_flag_a = match_a | (flag_a & ~i_compare_a_flag_clr & ~i_compare_a_irq_ack);
    wire next_flag_b = match_b | (flag_b & ~i_compare_b_flag_clr & ~i_compare_b_irq_ack);

    // block lasts until the next tick, also while stopped
    wire next_block = i_count_wr | (block_next & ~tick);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prescale   <= PRE_RESET;
            ext_prev   <= 1'b0;
            block_next <= 1'b0;
            count      <= CNT_RESET;
            ovf        <= 1'b0;
            flag_a     <= 1'b0;
            flag_b     <= 1'b0;
            oc_a       <= 1'b0;
            oc_b       <= 1'b0;
        end else if (i_ce) begin
            prescale   <= next_prescale;
            ext_prev   <= i_ext_clk_pin;
            block_next <= next_block;
            count      <= next_count;
            ovf        <= next_ovf;
            flag_a     <= next_flag_a;
            flag_b     <= next_flag_b;
            oc_a       <= next_oc_a;
            oc_b       <= next_oc_b;
        end
    end

    // override keyed on output mode alone; direction stays with port logic
    wire ovr_a = (i_compare_a_output_mode != COM_NONE);
    wire ovr_b = (i_compare_b_output_mode != COM_NONE);

    assign o_timer_count_value = count;
    assign o_overflow_flag     = ovf;
    assign o_compare_a_flag    = flag_a;
    assign o_compare_b_flag    = flag_b;
    assign o_compare_output_a  = oc_a;
    assign o_compare_output_b  = oc_b;
    assign o_pin_a_out  = ovr_a ? oc_a : i_port_a_value;
    assign o_pin_b_out  = ovr_b ? oc_b : i_port_b_value;
    assign o_pin_a_oe_n = ~i_compare_pin_direction_bit_a;
    assign o_pin_b_oe_n = ~i_compare_pin_direction_bit_b;

    // checks
    logic past_valid;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    a_write_blocks_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_count_wr ##1 (i_ce && tick && !i_count_wr && !i_compare_a_flag_clr
        && !i_compare_a_irq_ack && !flag_a) |=> !flag_a)
        else $error("compare flag set in tick after count write");
    a_reset_clears_oc: assert property (@(posedge i_clk)
        !i_rst_n |=> !o_compare_output_a && !o_compare_output_b)
        else $error("output state not cleared by reset");
    a_override_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_compare_a_output_mode != COM_NONE) |-> o_pin_a_out == o_compare_output_a)
        else $error("pin a not overridden");
    a_direction_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pin_a_oe_n == !i_compare_pin_direction_bit_a)
        else $error("pin a direction wrong");
    a_mode_zero_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_compare_a_output_mode == COM_NONE |=> $stable(o_compare_output_a))
        else $error("output a changed with mode zero");
    a_force_toggles: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_a && i_compare_a_output_mode == COM_TOGGLE
        |=> o_compare_output_a != $past(o_compare_output_a))
        else $error("force did not toggle output a");
    a_normal_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && !i_count_wr && i_waveform_gen_mode == WGM_NORMAL
        && count == CNT_MAX |=> count == CNT_BOTTOM && ovf)
        else $error("normal mode wrap or overflow wrong");
    a_ctc_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && !i_count_wr && mode_ctc && eq_a && !block_next |=> count == CNT_BOTTOM)
        else $error("ctc did not clear");
    a_write_priority: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_count_wr |=> count == $past(i_count_wdata))
        else $error("count write lost");
    a_stop_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        past_valid && i_ce && i_clock_select_field == CS_STOP && !i_count_wr
        |=> $stable(count))
        else $error("count moved while stopped");
    a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && match_a |=> o_compare_a_flag)
        else $error("compare a flag lost");

    // pin override and direction, channel b and pass-through
    a_override_pin_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_compare_b_output_mode != COM_NONE) |-> o_pin_b_out == o_compare_output_b)
        else $error("pin b not overridden");

    a_port_passes_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_compare_a_output_mode == COM_NONE) |-> o_pin_a_out == i_port_a_value)
        else $error("pin a port value lost");

    a_port_passes_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_compare_b_output_mode == COM_NONE) |-> o_pin_b_out == i_port_b_value)
        else $error("pin b port value lost");

    a_direction_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pin_b_oe_n == !i_compare_pin_direction_bit_b)
        else $error("pin b direction wrong");

    // output state actions
    a_mode_zero_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_compare_b_output_mode == COM_NONE |=> $stable(o_compare_output_b))
        else $error("output b changed with mode zero");

    a_force_sets_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_a && i_compare_a_output_mode == COM_SET
        |=> o_compare_output_a)
        else $error("force did not set output a");

    a_force_clears_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_a && i_compare_a_output_mode == COM_CLEAR
        |=> !o_compare_output_a)
        else $error("force did not clear output a");

    a_force_sets_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_b && i_compare_b_output_mode == COM_SET
        |=> o_compare_output_b)
        else $error("force did not set output b");

    a_force_clears_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_b && i_compare_b_output_mode == COM_CLEAR
        |=> !o_compare_output_b)
        else $error("force did not clear output b");

    a_force_toggles_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && non_pwm && i_force_compare_strobe_b && i_compare_b_output_mode == COM_TOGGLE
        |=> o_compare_output_b != $past(o_compare_output_b))
        else $error("force did not toggle output b");

    a_match_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && match_a && i_compare_a_output_mode == COM_TOGGLE
        |=> o_compare_output_a != $past(o_compare_output_a))
        else $error("match did not toggle output a");

    a_match_toggle_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && match_b && i_compare_b_output_mode == COM_TOGGLE
        |=> o_compare_output_b != $past(o_compare_output_b))
        else $error("match did not toggle output b");

    a_oc_a_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !act_a |=> $stable(o_compare_output_a))
        else $error("output a moved without an action");

    a_oc_b_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !act_b |=> $stable(o_compare_output_b))
        else $error("output b moved without an action");

    // forced compare leaves flags and counter alone
    a_force_no_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_force_compare_strobe_a && !match_a && !flag_a |=> !o_compare_a_flag)
        else $error("force set compare a flag");

    a_force_no_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_force_compare_strobe_a && !tick && !i_count_wr |=> $stable(count))
        else $error("force moved the count");

    // flags
    a_ovf_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ovf && !i_overflow_flag_clr && !i_overflow_irq_ack |=> ovf)
        else $error("overflow flag cleared itself");

    a_ovf_ack_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_overflow_irq_ack && !ovf_set |=> !ovf)
        else $error("overflow flag kept after service");

    a_ctc_wrap_ovf: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && mode_ctc && count == CNT_MAX && !eq_a |=> ovf)
        else $error("overflow flag missed in clear-on-match mode");

    a_ctc_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && mode_ctc && tick && eq_a && !block_next |=> o_compare_a_flag)
        else $error("compare a flag missed at top");

    a_flag_b_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && match_b |=> o_compare_b_flag)
        else $error("compare b flag lost");

    a_flag_a_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        flag_a && !i_compare_a_flag_clr && !i_compare_a_irq_ack |=> flag_a)
        else $error("compare a flag cleared itself");

    a_flag_b_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        flag_b && !i_compare_b_flag_clr && !i_compare_b_irq_ack |=> flag_b)
        else $error("compare b flag cleared itself");

    // counting
    a_normal_count_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && !i_count_wr && i_waveform_gen_mode == WGM_NORMAL
        |=> count == $past(count) + 8'h01)
        else $error("normal mode did not increment");

    a_ctc_count_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && !i_count_wr && mode_ctc && !eq_a
        |=> count == $past(count) + 8'h01)
        else $error("clear-on-match mode did not increment");

    a_blocked_no_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && tick && block_next && mode_ctc && eq_a && !i_count_wr
        |=> count == $past(count) + 8'h01)
        else $error("blocked match still cleared the count");

    a_stop_no_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_clock_select_field == CS_STOP |-> !tick)
        else $error("tick while stopped");

    // a low enable must freeze the count, the overflow flag and both output states
    a_ce_freezes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ce |=> $stable(count) && $stable(ovf) && $stable(oc_a) && $stable(oc_b))
        else $error("state moved with enable low");

    c_ctc_toggle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        mode_ctc && match_a && i_compare_a_output_mode == COM_TOGGLE);
    c_overflow: cover property (@(posedge i_clk) disable iff (!i_rst_n) ovf_set);
    c_blocked: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && eq_a && block_next);
    c_force: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_force_compare_strobe_b && non_pwm);
    c_ovf_service: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        ovf && i_overflow_irq_ack);
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb;
    import tcmp_pkg::*;
    localparam logic [1:0] MODES [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_NONE};
    localparam logic [3:0] OC_EXP    = 4'b1101;
    logic       i_clk, i_rst_n, i_ce, ext_pin, cnt_wr;
    logic       port_a, port_b, dir_a, dir_b;
    logic [2:0] cs, wgm;
    logic [1:0] com_a, com_b;
    logic [7:0] ocr_a, ocr_b, wdata, stb, count;
    logic       ovf, flag_a, flag_b, oc_a, oc_b, pin_a, oe_a_n, pin_b, oe_b_n;
    int         err_count, checks, cyc;

    tcmp_timer dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_clock_select_field(cs),
        .i_waveform_gen_mode(wgm), .i_compare_a_output_mode(com_a),
        .i_compare_b_output_mode(com_b), .i_compare_a_value(ocr_a),
        .i_compare_b_value(ocr_b), .i_ext_clk_pin(ext_pin), .i_count_wr(cnt_wr),
        .i_count_wdata(wdata), .i_force_compare_strobe_a(stb[0]),
        .i_force_compare_strobe_b(stb[1]), .i_compare_a_flag_clr(stb[2]),
        .i_compare_b_flag_clr(stb[3]), .i_overflow_flag_clr(stb[4]),
        .i_compare_a_irq_ack(stb[5]), .i_compare_b_irq_ack(stb[6]),
        .i_overflow_irq_ack(stb[7]), .i_port_a_value(port_a), .i_port_b_value(port_b),
        .i_compare_pin_direction_bit_a(dir_a), .i_compare_pin_direction_bit_b(dir_b),
        .o_timer_count_value(count), .o_overflow_flag(ovf), .o_compare_a_flag(flag_a),
        .o_compare_b_flag(flag_b), .o_compare_output_a(oc_a), .o_compare_output_b(oc_b),
        .o_pin_a_out(pin_a), .o_pin_a_oe_n(oe_a_n), .o_pin_b_out(pin_b),
        .o_pin_b_oe_n(oe_b_n)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // n rising edges, then settle at the falling edge
    task automatic run(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic pulse(input logic [7:0] mask);
        @(posedge i_clk);
        stb <= mask;
        @(posedge i_clk);
        stb <= 8'h00;
        @(negedge i_clk);
    endtask

    // clock select changes on the write edge, so with CS_DIV1 the next edge is the first tick
    task automatic write_count(input logic [7:0] v, input logic [2:0] cs_after);
        @(posedge i_clk);
        cnt_wr <= 1'b1;
        wdata <= v;
        @(posedge i_clk);
        cnt_wr <= 1'b0;
        cs <= cs_after;
        @(negedge i_clk);
    endtask

    // hang guard: the whole sequence needs well under 600 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        {i_rst_n, ext_pin, cnt_wr, port_a, dir_b} = 5'h00;
        {i_ce, port_b, dir_a} = 3'h7;
        {cs, wgm, com_a, com_b} = 10'h000;
        {ocr_a, ocr_b, wdata, stb} = 32'h8080_0000;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk("count", count, CNT_RESET);
        chk("oc", {6'h00, oc_a, oc_b}, 8'h00);
        chk("flags", {5'h00, ovf, flag_a, flag_b}, 8'h00);
        chk("pins", {4'h0, pin_a, oe_a_n, pin_b, oe_b_n}, 8'h03);
        write_count(8'h40, CS_STOP);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            com_a <= MODES[i];
            com_b <= MODES[i];
            pulse(8'h03);
            chk("oc force", {6'h00, oc_a, oc_b}, {6'h00, {2{OC_EXP[i]}}});
            chk("pin a", {7'h00, pin_a}, {7'h00, (i == 3) ? 1'b0 : OC_EXP[i]});
            chk("pin b", {6'h00, pin_b, oe_b_n}, {6'h00, (i == 3) ? 1'b1 : OC_EXP[i], 1'b1});
        end
        chk("force side", {count, 5'h00, ovf, flag_a, flag_b}, 16'h4000);
        write_count(8'hfe, CS_DIV1);
        run(1);
        chk("count max", {count, 7'h00, ovf}, 16'hff00);
        run(1);
        chk("wrap", {count, 7'h00, ovf}, 16'h0001);
        @(posedge i_clk);
        cs <= CS_STOP;
        run(3);
        chk("stopped", {count, 7'h00, ovf}, 16'h0101);
        pulse(8'h80);
        chk("ovf ack", {7'h00, ovf}, 8'h00);
        @(posedge i_clk);
        wgm <= WGM_CTC;
        ocr_a <= 8'h03;
        com_a <= COM_TOGGLE;
        write_count(8'h00, CS_DIV1);
        chk("mode change", {7'h00, oc_a}, 8'h01);
        run(3);
        chk("top", {count, 7'h00, flag_a}, 16'h0300);
        run(1);
        chk("clear", {count, 5'h00, flag_a, oc_a, pin_a}, 16'h0004);
        run(4);
        chk("toggle", {count, 7'h00, oc_a}, 16'h0001);
        pulse(8'h04);
        chk("flag clr", {7'h00, flag_a}, 8'h00);
        @(posedge i_clk);
        com_a <= COM_NONE;
        run(1);
        chk("no action", {count, 6'h00, flag_a, oc_a}, 16'h0003);
        @(posedge i_clk);
        cs <= CS_STOP;
        pulse(8'h14);
        write_count(8'h03, CS_DIV1);
        run(1);
        chk("blocked", {count, 7'h00, flag_a}, 16'h0400);
        run(251);
        chk("pass top", count, CNT_MAX);
        run(1);
        chk("ctc wrap", {count, 6'h00, ovf, flag_a}, 16'h0002);
        run(4);
        chk("late match", {count, 7'h00, flag_a}, 16'h0001);
        chk("flag b", {7'h00, flag_b}, 8'h01);
        write_count(8'h00, CS_DIV8);
        run(8);
        chk("div8", count, 16'h0001);
        finish_test();
    end
endmodule
